// >>> include/ramp_pkg.sv
// constants, register map and carrier types of the frequency limit and ramp block
// assumes a 25 MHz pclk and 32-bit APB data; frequencies in 0.01 Hz, percent in 1 %
package ramp_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned AUTO_TICKS = 100;
  localparam logic [8:0] GAIN_FULL = 9'h100;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FCMD = 8'h04;
  localparam logic [7:0] A_FMAX = 8'h08;
  localparam logic [7:0] A_FMIN = 8'h0C;
  localparam logic [7:0] A_LIMIT = 8'h10;
  localparam logic [7:0] A_MODE = 8'h14;
  localparam logic [7:0] A_TSET = 8'h18;
  localparam logic [7:0] A_TSET_END = 8'h34;
  localparam logic [7:0] A_JOGACC = 8'h38;
  localparam logic [7:0] A_JOGDEC = 8'h3C;
  localparam logic [7:0] A_JOGFRQ = 8'h40;
  localparam logic [7:0] A_STATUS = 8'h44;
  localparam logic [7:0] A_LIMSTAT = 8'h48;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_RUN = 0;
  localparam int CTRL_REV = 1;
  localparam int CTRL_JOG = 2;
  localparam int CTRL_KSTOP = 3;
  localparam int CTRL_KFWD = 4;
  localparam int CTRL_KREV = 5;
  localparam int LIM_UP = 0;
  localparam int LIM_LO = 8;
  localparam int MODE_UNIT = 0;
  localparam int MODE_AUTO = 4;
  localparam int MODE_SACC = 8;
  localparam int MODE_SDEC = 12;
  // ---------------------------------------------------------------
  // reset values and setting ranges
  // ---------------------------------------------------------------
  localparam logic [15:0] FMAX_RST = 16'h1770;
  localparam logic [15:0] FMAX_MIN = 16'h1388;
  localparam logic [15:0] FREQ_TOP = 16'h9C40;
  localparam logic [15:0] FMIN_RST = 16'h0032;
  localparam logic [15:0] FMIN_MIN = 16'h000A;
  localparam logic [7:0] UPCT_RST = 8'h64;
  localparam logic [7:0] UPCT_TOP = 8'h78;
  localparam logic [7:0] LPCT_RST = 8'h00;
  localparam logic [7:0] LPCT_TOP = 8'h64;
  localparam logic [1:0] UNIT_RST = 2'h1;
  localparam logic [15:0] TIME_RST = 16'h0064;
  localparam logic [15:0] TIME_RST_BIG = 16'h0258;
  localparam logic [15:0] TIME_TOP = 16'h8CA0;
  localparam logic [15:0] JOGT_RST = 16'h000A;
  localparam logic [15:0] JOGF_RST = 16'h0064;
  localparam logic [2:0] AUTO_TOP = 3'h4;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00, PH_ACCEL = 2'b01, PH_CONST = 2'b11, PH_DECEL = 2'b10
  } phase_t;
  typedef struct packed {
    logic run; logic rev; logic jog; logic [1:0] set_sel;
    logic over_current; logic over_voltage;
  } pins_t;
  typedef struct packed {
    logic [15:0] freq; logic rev; logic run; logic jog; phase_t phase;
  } drive_t;
endpackage : ramp_pkg

// >>> rtl/freq_ramp.sv
// frequency limit clamp and acceleration/deceleration ramp generator, APB slave
// assumes pins come from outside pclk's domain; APB master on pclk
// Behaviour
// [R1] upper limit equals max frequency times 1..120 percent over 100
// [R2] output never exceeds the upper limit
// [R3] lower limit from 0..100 percent; commands above minimum lift to it
// [R4] software keeps lower percent at or below upper percent
// [R5] software keeps voltage and frequency curve points ordered
// [R6] ramp times accept 0.01 to 3600.0 s, default 10.0 or 60 s
// [R7] unit selector: 00 one second, 01 tenth, 02 hundredth
// [R8] acceleration time spans 0 Hz to maximum frequency, linear
// [R9] deceleration time spans maximum frequency to 0 Hz, linear
// [R10] four time sets chosen by input terminals
// [R11] ramp slope fixed by full span; partial changes take proportional time
// [R12] jog times 0.1 to 3600.0 s, default 1.0 s
// [R13] jog ramps from minimum frequency to jog frequency 0.10..400.00 Hz
// [R14] jog release ramps to zero with jog deceleration time
// [R15] commander stops the drive before jogging
// [R16] while jogging only keypad forward, reverse and stop are obeyed
// [R17] auto ramp selector codes 00 through 04
// [R18] mode 04 ramps never faster than configured times
// [R19] auto ramps pause on high current or high regenerative voltage
// [R20] auto deceleration not advised with braking resistor
// [R21] S-curve settings 00 off, 01..07 on, 07 smoothest
// [R22] with S-curve on, duration follows smoothing level
// [R23] ramp target is clamped to the limits first
`timescale 1ns/1ps
module freq_ramp
  import ramp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter bit LARGE_RATING = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pins_t pins,
  output drive_t drive
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    pins_t sync1;
    pins_t sync2;
    logic [31:0] prdata;
    logic c_run; logic c_rev; logic c_jog;
    logic [15:0] fcmd; logic [15:0] fmax; logic [15:0] fmin;
    logic [7:0] upct; logic [7:0] lpct;
    logic [1:0] unit; logic [2:0] auto_mode; logic [2:0] sacc; logic [2:0] sdec;
    logic [7:0][15:0] tset;
    logic [15:0] jacc; logic [15:0] jdec; logic [15:0] jfreq;
    logic [15:0] hi; logic [15:0] lo;
    logic kp_rev; logic stop_hold;
    logic [31:0] tick_cnt;
    logic [31:0] acc;
    logic [8:0] gain;
    drive_t drv;
  } st_t;

  localparam logic [15:0] TRST = LARGE_RATING ? TIME_RST_BIG : TIME_RST;

  st_t s;
  st_t next_s;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [15:0] pct_of(input logic [15:0] f, input logic [7:0] p);
    logic [23:0] prod;
    prod = f * p;
    return 16'(prod / 24'd100);
  endfunction : pct_of

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction : clamp16

  function automatic logic [21:0] span_ticks(input logic [15:0] t, input logic [1:0] u);
    logic [21:0] w;
    w = {6'h00, t};
    case (u)
      2'h0: span_ticks = 22'(w * 22'd100);
      2'h1: span_ticks = 22'(w * 22'd10);
      default: span_ticks = w;
    endcase
    if (span_ticks == 22'h00_0000) span_ticks = 22'h00_0001;
  endfunction : span_ticks

  // ---------------------------------------------------------------
  // combinational helpers
  // ---------------------------------------------------------------
  pins_t p;
  logic wr, rd_setup, hit, tick, jog_req, run_req, want_rev;
  logic up, dn, fast, paused, kstop, kfwd, krev;
  logic [2:0] tidx, level;
  logic [15:0] cmd_clamped, goal, tval, remain;
  logic [1:0] tunit;
  logic [21:0] span;
  logic [31:0] thr, rdata;
  logic [8:0] gstep;

  // ---------------------------------------------------------------
  // apb handshake
  // ---------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = s.prdata;

  always_comb begin
    next_s = s;
    // two-stage pin synchroniser; only sync2 is read
    next_s.sync1 = pins;
    next_s.sync2 = s.sync1;
    p = s.sync2;

    wr = psel & penable & pwrite;
    rd_setup = psel & ~penable & ~pwrite;
    tidx = 3'(paddr[7:2] - A_TSET[7:2]);
    hit = (paddr[1:0] == 2'b00) && (paddr <= A_LIMSTAT);

    // ---------------------------------------------------------------
    // register read mux
    // ---------------------------------------------------------------
    rdata = 32'h0000_0000;
    if (paddr >= A_TSET && paddr <= A_TSET_END && paddr[1:0] == 2'b00) begin
      rdata = {16'h0000, s.tset[tidx]};
    end else begin
      case (paddr)
        A_CTRL: rdata = {29'h0000_0000, s.c_jog, s.c_rev, s.c_run};
        A_FCMD: rdata = {16'h0000, s.fcmd};
        A_FMAX: rdata = {16'h0000, s.fmax};
        A_FMIN: rdata = {16'h0000, s.fmin};
        A_LIMIT: rdata = {16'h0000, s.lpct, s.upct};
        A_MODE: rdata = {17'h0_0000, s.sdec, 1'b0, s.sacc, 1'b0, s.auto_mode, 2'b00, s.unit};
        A_JOGACC: rdata = {16'h0000, s.jacc};
        A_JOGDEC: rdata = {16'h0000, s.jdec};
        A_JOGFRQ: rdata = {16'h0000, s.jfreq};
        A_STATUS: rdata = {10'h000, s.stop_hold, s.drv.jog, s.drv.rev, s.drv.run,
                           s.drv.phase, s.drv.freq};
        A_LIMSTAT: rdata = {s.lo, s.hi};
        default: rdata = 32'h0000_0000;
      endcase
    end
    if (rd_setup) next_s.prdata = rdata;

    // ---------------------------------------------------------------
    // register writes, settings clamped to their ranges
    // ---------------------------------------------------------------
    kstop = wr && paddr == A_CTRL && pwdata[CTRL_KSTOP];
    kfwd = wr && paddr == A_CTRL && pwdata[CTRL_KFWD];
    krev = wr && paddr == A_CTRL && pwdata[CTRL_KREV];
    if (wr && paddr >= A_TSET && paddr <= A_TSET_END && paddr[1:0] == 2'b00) begin
      next_s.tset[tidx] = clamp16(pwdata[15:0], 16'h0001, TIME_TOP); // R6
    end
    if (wr) begin
      case (paddr)
        A_CTRL: begin
          next_s.c_run = pwdata[CTRL_RUN];
          next_s.c_rev = pwdata[CTRL_REV];
          next_s.c_jog = pwdata[CTRL_JOG];
        end
        A_FCMD: next_s.fcmd = clamp16(pwdata[15:0], 16'h0000, FREQ_TOP);
        A_FMAX: next_s.fmax = clamp16(pwdata[15:0], FMAX_MIN, FREQ_TOP);
        A_FMIN: next_s.fmin = clamp16(pwdata[15:0], FMIN_MIN, FREQ_TOP);
        A_LIMIT: begin
          next_s.upct = 8'(clamp16({8'h00, pwdata[LIM_UP+:8]}, 16'h0001,
                                   {8'h00, UPCT_TOP})); // R1
          next_s.lpct = 8'(clamp16({8'h00, pwdata[LIM_LO+:8]}, 16'h0000,
                                   {8'h00, LPCT_TOP})); // R3
        end
        A_MODE: begin
          next_s.unit = (pwdata[MODE_UNIT+:2] == 2'h3) ? 2'h2 : pwdata[MODE_UNIT+:2]; // R7
          next_s.auto_mode = (pwdata[MODE_AUTO+:3] > AUTO_TOP) ? AUTO_TOP
                                                                : pwdata[MODE_AUTO+:3]; // R17
          next_s.sacc = pwdata[MODE_SACC+:3]; // R21
          next_s.sdec = pwdata[MODE_SDEC+:3]; // R21
        end
        A_JOGACC: next_s.jacc = clamp16(pwdata[15:0], 16'h0001, TIME_TOP); // R12
        A_JOGDEC: next_s.jdec = clamp16(pwdata[15:0], 16'h0001, TIME_TOP); // R12
        A_JOGFRQ: next_s.jfreq = clamp16(pwdata[15:0], FMIN_MIN, FREQ_TOP); // R13
        default: ;
      endcase
    end

    // ---------------------------------------------------------------
    // limits and command conditioning
    // ---------------------------------------------------------------
    next_s.hi = pct_of(s.fmax, s.upct); // R1
    next_s.lo = pct_of(s.fmax, s.lpct); // R3
    // below minimum frequency nothing runs; otherwise lower wins first, upper last
    if (s.fcmd < s.fmin) cmd_clamped = 16'h0000;
    else cmd_clamped = clamp16(s.fcmd, s.lo, s.hi); // R3 R2 R23

    // ---------------------------------------------------------------
    // run, stop and jog commands
    // ---------------------------------------------------------------
    jog_req = p.jog | s.c_jog;
    run_req = p.run | s.c_run;
    if (kfwd) next_s.kp_rev = 1'b0;
    if (krev) next_s.kp_rev = 1'b1;
    if (kstop) next_s.stop_hold = 1'b1;
    else if (!run_req && !jog_req) next_s.stop_hold = 1'b0;
    // jog only starts from standstill
    if (!s.drv.jog && jog_req && !run_req && !s.stop_hold && s.drv.freq == 16'h0000) begin
      next_s.drv.jog = 1'b1; // R13 R15
    end else if (s.drv.jog && (!jog_req || s.stop_hold) && s.drv.freq == 16'h0000) begin
      next_s.drv.jog = 1'b0; // R14
    end
    if (s.drv.jog) begin
      // terminal and serial run/direction ignored; keypad keys still act
      want_rev = s.kp_rev; // R16
      goal = (jog_req && !s.stop_hold) ? clamp16(s.jfreq, 16'h0000, s.hi) // R13 R2
                                       : 16'h0000; // R14
    end else begin
      want_rev = p.rev | s.c_rev;
      goal = (run_req && !s.stop_hold) ? cmd_clamped : 16'h0000;
    end
    // reversing passes through zero first
    if (want_rev != s.drv.rev) goal = 16'h0000;
    if (s.drv.freq == 16'h0000) next_s.drv.rev = want_rev;

    // ---------------------------------------------------------------
    // ramp rate selection
    // ---------------------------------------------------------------
    up = goal > s.drv.freq;
    dn = goal < s.drv.freq;
    remain = up ? 16'(goal - s.drv.freq) : 16'(s.drv.freq - goal);
    if (s.drv.jog) begin
      tval = up ? s.jacc : s.jdec; // R12 R14
      tunit = UNIT_RST;
    end else begin
      tval = s.tset[{p.set_sel, ~up}]; // R10
      tunit = s.unit; // R7
    end
    fast = 1'b0;
    paused = 1'b0;
    if (!s.drv.jog) begin
      case (s.auto_mode)
        3'h1: begin
          fast = up; // R17
          paused = up & p.over_current; // R19
        end
        3'h2: begin
          fast = dn; // R17
          paused = dn & p.over_voltage; // R19
        end
        3'h3: begin
          fast = 1'b1; // R17
          paused = up ? p.over_current : p.over_voltage; // R19
        end
        3'h4: begin
          // configured time is the floor, pauses only stretch it
          paused = up ? p.over_current : p.over_voltage; // R18 R19
        end
        default: ;
      endcase
    end
    span = fast ? 22'(AUTO_TICKS) : span_ticks(tval, tunit); // R8 R9
    thr = {2'b00, span, 8'h00};

    // ---------------------------------------------------------------
    // s-curve gain shaping
    // ---------------------------------------------------------------
    level = up ? s.sacc : s.sdec;
    gstep = GAIN_FULL >> level; // R21
    tick = s.tick_cnt == 32'(TICK_CYCLES - 1);
    next_s.tick_cnt = tick ? 32'h0000_0000 : 32'(s.tick_cnt + 32'h0000_0001);
    if (level == 3'h0) begin
      next_s.gain = GAIN_FULL; // R8 R9
    end else if (!up && !dn) begin
      next_s.gain = gstep;
    end else if (tick) begin
      // ease in from rest, ease out near the goal
      if (remain <= 16'(((s.fmax >> 3) * level) >> 3)) begin
        next_s.gain = (s.gain > 9'(gstep << 1)) ? 9'(s.gain - gstep) : gstep; // R22
      end else begin
        next_s.gain = (s.gain < 9'(GAIN_FULL - gstep)) ? 9'(s.gain + gstep)
                                                       : GAIN_FULL; // R22
      end
    end

    // ---------------------------------------------------------------
    // ramp stepping: jump from 0 to minimum frequency, then full-span rate, at most one 0.01 Hz step per clock
    // ---------------------------------------------------------------
    if (!up && !dn) begin
      next_s.acc = 32'h0000_0000;
    end else if (up && s.drv.freq == 16'h0000) begin
      // start at minimum frequency
      next_s.drv.freq = (goal < s.fmin) ? goal : s.fmin; // R13
      next_s.acc = 32'h0000_0000;
    end else begin
      if (tick && !paused) begin
        next_s.acc = 32'(s.acc + s.fmax * s.gain); // R11
      end
      if (s.acc >= thr) begin
        next_s.acc = 32'(next_s.acc - thr); // R11
        next_s.drv.freq = up ? 16'(s.drv.freq + 16'h0001)
                             : 16'(s.drv.freq - 16'h0001); // R8 R9
      end
    end
    // a lowered upper limit pulls the output down at once
    if (next_s.drv.freq > s.hi) next_s.drv.freq = s.hi; // R2

    // ---------------------------------------------------------------
    // status flags
    // ---------------------------------------------------------------
    next_s.drv.run = next_s.drv.freq != 16'h0000;
    if (s.drv.freq == 16'h0000 && goal == 16'h0000) next_s.drv.phase = PH_IDLE;
    else if (up) next_s.drv.phase = PH_ACCEL;
    else if (dn) next_s.drv.phase = PH_DECEL;
    else next_s.drv.phase = PH_CONST;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.fmax <= FMAX_RST;
      s.fmin <= FMIN_RST;
      s.upct <= UPCT_RST;
      s.lpct <= LPCT_RST;
      s.unit <= UNIT_RST;
      s.tset <= {8{TRST}};
      s.jacc <= JOGT_RST;
      s.jdec <= JOGT_RST;
      s.jfreq <= JOGF_RST;
      s.hi <= FMAX_RST;
      s.gain <= GAIN_FULL;
      s.drv.phase <= PH_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign drive = s.drv;

endmodule : freq_ramp

// >>> tb/inverter_stage.sv
// model of the inverter output stage that consumes the ramped frequency
// assumes pclk domain; stall asks the load to push back on the ramp
`timescale 1ns/1ps
module inverter_stage
  import ramp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire drive_t drive,
  input wire logic stall,
  output logic over_current,
  output logic over_voltage
);
  // current alarm while speeding up, bus voltage alarm while braking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_current <= 1'b0;
      over_voltage <= 1'b0;
    end else begin
      over_current <= stall && drive.phase == PH_ACCEL;
      over_voltage <= stall && drive.phase == PH_DECEL;
    end
  end
endmodule : inverter_stage

// >>> tb/freq_ramp_sva.sv
// port assertions of the frequency limit and ramp block
// assumes ramp_pkg; bound into freq_ramp at the foot of this file
`timescale 1ns/1ps
module freq_ramp_sva
  import ramp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire pins_t pins,
  input wire drive_t drive
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc;
  logic bad;
  assign acc = psel && penable;
  assign bad = paddr > A_LIMSTAT || paddr[1:0] != 2'b00;
  a_err_unmapped: assert property (acc && bad |-> pslverr && (pwrite || prdata == '0))
    else $error("unmapped access not refused");
  a_err_mapped: assert property (acc && !bad |-> !pslverr)
    else $error("mapped access refused");
  a_rd_status: assert property (acc && !pwrite && paddr == A_STATUS
    |-> prdata[15:0] == $past(drive.freq))
    else $error("status read differs from output frequency");
  a_run_flag: assert property (drive.run == (drive.freq != '0))
    else $error("run flag disagrees with frequency");
  a_step_one: assert property ($past(drive.freq) != '0 && drive.freq > $past(drive.freq)
    |-> drive.freq == $past(drive.freq) + 16'h0001)
    else $error("frequency rose by more than one count");
  a_idle_zero: assert property (drive.phase == PH_IDLE |-> drive.freq == '0)
    else $error("idle phase with nonzero frequency");
  a_rev_at_zero: assert property ($changed(drive.rev) |-> $past(drive.freq) == '0)
    else $error("direction flipped while turning");
  a_const_hold: assert property ($past(drive.phase) == PH_CONST && drive.phase == PH_CONST
    |-> $stable(drive.freq))
    else $error("frequency moved in constant phase");
  a_jog_rev: assert property (drive.jog && $changed(pins.rev) |=> $stable(drive.rev) [*4])
    else $error("direction pin obeyed while jogging");
  c_jog: cover property (drive.jog && drive.phase == PH_CONST);
  c_stall: cover property (pins.over_current && drive.phase == PH_ACCEL);
  c_err: cover property (acc && bad);
endmodule : freq_ramp_sva

bind freq_ramp freq_ramp_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
  .drive(drive));

// >>> tb/freq_limit_ramp_generator_tb.sv
// self-checking bench of the frequency limit and ramp block
// assumes ramp_pkg, freq_ramp, the checker and inverter_stage compiled first
`timescale 1ns/1ps
module freq_limit_ramp_generator_tb
  import ramp_pkg::*;
;
  localparam int TK = 64;
  localparam int TOL = 2 * TK + 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic rn, rv, jg, stall, oc, ov;
  logic [1:0] ss;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  pins_t pins;
  drive_t drv;
  int bad_count, tests_run, n, d1, fm, up, lo, t, g;
  assign pins = {rn, rv, jg, ss, oc, ov};
  freq_ramp #(.TICK_CYCLES(TK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .drive(drv));
  inverter_stage load (.pclk(pclk), .presetn(presetn), .drive(drv), .stall(stall),
    .over_current(oc), .over_voltage(ov));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, want, input string m);
    tests_run++;
    if (got !== want) begin
      bad_count++;
      $display("ERROR %0t %s: got %h want %h", $time, m, got, want);
    end
  endtask : chk
  task automatic near(input int got, want, input string m);
    tests_run++;
    if (got < want - TOL || got > want + TOL) begin
      bad_count++;
      $display("ERROR %0t %s: %0d cycles, want %0d", $time, m, got, want);
    end
  endtask : near
  // apb transfer, entered and left just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  function automatic logic [31:0] rst_val(logic [7:0] a);
    case (a)
      A_FMAX: return 32'(FMAX_RST);
      A_FMIN: return 32'(FMIN_RST);
      A_LIMIT: return 32'h0000_0064;
      A_MODE: return 32'h0000_0001;
      A_JOGACC, A_JOGDEC: return 32'h0000_000a;
      A_JOGFRQ: return 32'(JOGF_RST);
      default: return 32'h0000_0064;
    endcase
  endfunction : rst_val
  // cycles for a change of dl counts at full span 5000 and time t in unit u
  function automatic int cyc(int dl, tt, u);
    return dl * tt * (u == 0 ? 100 : u == 1 ? 10 : 1) * TK / 5000;
  endfunction : cyc
  // counts cycles from frequency a to b, stalling the load st cycles once a is seen
  task automatic meas(input logic [15:0] a, b, input int st);
    int i;
    for (i = 0; drv.freq !== a && i < 30000; i++) @(negedge pclk);
    if (st > 0) fork
      begin
        @(posedge pclk);
        stall <= 1'b1;
        repeat (st) @(posedge pclk);
        stall <= 1'b0;
      end
    join_none
    for (n = 0; drv.freq !== b && n < 30000; n++) @(negedge pclk);
    @(posedge pclk);
  endtask : meas
  task automatic ramp(input int c, gl, ta, td, u, st, input string m);
    apb(1'b1, A_FCMD, c);
    rn <= 1'b1;
    meas(16'(100), 16'(gl), st);
    near(n, cyc(gl - 100, ta, u) + st, m);
    repeat (50) @(negedge pclk);
    chk(drv.freq, gl, m);
    @(posedge pclk);
    rn <= 1'b0;
    meas(16'(gl - 100), 16'h0000, st);
    near(n, cyc(gl - 100, td, u) + st, m);
    $display("test %s done", m);
  endtask : ramp
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (95000) @(posedge pclk);
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rn, rv, jg, ss, stall} = '0;
    bad_count = 0;
    tests_run = 0;
    presetn = 1'b0;
    d1 = $urandom(32'h0000_f984);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 8; a <= 'h40; a += 4) begin
      apb(1'b0, 8'(a), '0);
      chk(q, rst_val(8'(a)), "reset value");
    end
    apb(1'b1, A_STATUS, '1);
    apb(1'b0, A_STATUS, '0);
    chk(q, '0, "status write ignored");
    for (int k = 0; k < 2; k++) begin
      apb(1'b0, k == 0 ? 8'h4c : 8'h06, '0);
      chk({q[30:0], e}, 32'h0000_0001, "unmapped read");
    end
    $display("test registers done");
    apb(1'b1, A_MODE, 32'h0000_0002);
    for (int k = 0; k < 6; k++) begin
      fm = 5000 + $urandom_range(3000);
      up = 1 + $urandom_range(119);
      lo = $urandom_range(up > 100 ? 100 : up);
      apb(1'b1, A_FMAX, fm);
      apb(1'b1, A_LIMIT, 32'({lo[7:0], up[7:0]}));
      apb(1'b0, A_LIMSTAT, '0);
      chk(q, {16'(fm * lo / 100), 16'(fm * up / 100)}, "limits");
    end
    apb(1'b1, A_LIMIT, 32'h0000_96c8);
    apb(1'b0, A_LIMIT, '0);
    chk(q, 32'h0000_6478, "limit range");
    apb(1'b1, A_FMAX, 32'h0000_1388);
    apb(1'b1, A_LIMIT, 32'h0000_1432);
    ramp(4000, 2500, 100, 100, 2, 0, "upper clamp");
    rv <= 1'b1;
    ramp(500, 1000, 100, 100, 2, 0, "lower lift");
    rv <= 1'b0;
    apb(1'b1, A_LIMIT, 32'h0000_0064);
    for (int u = 0; u < 3; u++) begin
      t = u == 0 ? 1 : u == 1 ? 10 : 100;
      apb(1'b1, A_MODE, u);
      apb(1'b1, A_TSET, t);
      apb(1'b1, A_TSET + 8'h04, t);
      ramp(1000, 1000, t, t, u, 0, "time unit");
    end
    for (int k = 0; k < 4; k++) begin
      ss <= 2'(k);
      g = 400 + $urandom_range(600);
      // spans of 80 ticks or more keep the slope under one count per clock
      apb(1'b1, A_TSET + 8'(8 * k), 80 * (k + 1));
      apb(1'b1, A_TSET + 8'(8 * k + 4), 40 * (k + 2));
      ramp(g, g, 80 * (k + 1), 40 * (k + 2), 2, 0, "time set");
    end
    ss <= 2'h0;
    apb(1'b1, A_TSET, 32'h0000_00c8);
    apb(1'b1, A_TSET + 8'h04, 32'h0000_00c8);
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, A_MODE, 32'(m * 16 + 2));
      ramp(600, 600, m == 1 || m == 3 ? 100 : 200, m == 2 || m == 3 ? 100 : 200, 2,
        m == 4 ? 200 : 0, "auto mode");
    end
    apb(1'b1, A_TSET, 32'h0000_0008);
    apb(1'b1, A_TSET + 8'h04, 32'h0000_0008);
    g = 0;
    for (int s = 1; s < 8; s++) begin
      apb(1'b1, A_MODE, 32'(s * 'h1100 + 2));
      apb(1'b1, A_FCMD, 32'h0000_012c);
      rn <= 1'b1;
      meas(16'h0064, 16'h012c, 0);
      if (s == 1) d1 = n;
      // each level is no quicker than the one below, within one tick
      chk(n + TK >= g && n < 30000, 1, "s-curve accel");
      if (s == 7) chk(n > d1, 1, "s-curve level order");
      g = n;
      rn <= 1'b0;
      meas(16'h0064, 16'h0000, 0);
      chk(n < 30000, 1, "s-curve decel");
    end
    $display("test s-curve done");
    apb(1'b1, A_MODE, 32'h0000_0002);
    apb(1'b1, A_JOGFRQ, 32'h0000_0320);
    apb(1'b1, A_JOGDEC, 32'h0000_0014);
    jg <= 1'b1;
    meas(16'h0064, 16'h0320, 0);
    near(n, cyc(700, 10, 1), "jog accel");
    rn <= 1'b1;
    rv <= 1'b1;
    repeat (200) @(negedge pclk);
    chk({drv.jog, drv.rev, drv.freq}, {2'b10, 16'h0320}, "jog ignores run");
    @(posedge pclk);
    {rn, rv, jg} <= 3'b000;
    meas(16'h02bc, 16'h0000, 0);
    near(n, cyc(700, 20, 1), "jog decel");
    jg <= 1'b1;
    meas(16'h0064, 16'h0320, 0);
    apb(1'b1, A_CTRL, 32'h0000_0008);
    meas(16'h02bc, 16'h0000, 0);
    chk(n < 30000, 1, "keypad stop in jog");
    jg <= 1'b0;
    $display("test jog done");
    report_and_stop();
  end
endmodule : freq_limit_ramp_generator_tb
